/* hdl/acrm_pkg.sv */
package acrm_pkg;

  // clock and bus
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;

  // register offsets
  localparam logic [7:0] OFS_SAMPLE_RATE_MON  = 8'h37;
  localparam logic [7:0] OFS_BIT_CLK_RATIO_LO = 8'h38;
  localparam logic [7:0] OFS_CLK_DETECT_FLAGS = 8'h39;
  localparam logic [7:0] OFS_RATE_CTRL        = 8'h3A;
  localparam logic [7:0] OFS_IRQ_STATUS       = 8'h3B;
  localparam logic [7:0] OFS_IRQ_MASK         = 8'h3C;

  // reset values
  localparam logic [7:0] RST_SAMPLE_RATE_MON  = 8'h00;
  localparam logic [7:0] RST_BIT_CLK_RATIO_LO = 8'h00;
  localparam logic [7:0] RST_CLK_DETECT_FLAGS = 8'h00;
  localparam logic [4:0] RST_RATE_CTRL        = 5'h00;
  localparam logic [4:0] RST_IRQ              = 5'h00;

  // field positions
  localparam int unsigned RATIO_HI_LSB  = 4;
  localparam int unsigned RSV_LSB       = 6;
  localparam int unsigned FLG_BCK_RATE  = 5;
  localparam int unsigned FLG_PLL_OVR   = 4;
  localparam int unsigned FLG_PLL_LOCK  = 3;
  localparam int unsigned FLG_BCK_MISS  = 2;
  localparam int unsigned FLG_BCK_VALID = 1;
  localparam int unsigned FLG_RATE      = 0;
  localparam int unsigned CTRL_IGNORE   = 4;

  // interrupt bits
  localparam int unsigned IRQ_BCK_MISS  = 0;
  localparam int unsigned IRQ_BCK_RATE  = 1;
  localparam int unsigned IRQ_PLL_UNLK  = 2;
  localparam int unsigned IRQ_PLL_OVR   = 3;
  localparam int unsigned IRQ_RATE_ERR  = 4;
  localparam int unsigned IRQ_N         = 5;

  // detected rate codes
  localparam logic [3:0] RATE_ERR = 4'h0;
  localparam logic [3:0] RATE_8K  = 4'h2;
  localparam logic [3:0] RATE_16K = 4'h4;
  localparam logic [3:0] RATE_32K = 4'h6;
  localparam logic [3:0] RATE_48K = 4'h9;
  localparam logic [3:0] RATE_96K = 4'hB;

  // bit clock ratio limits, in bit clocks per frame
  localparam int unsigned RATIO_W   = 10;
  localparam logic [9:0]  RATIO_MIN = 10'h020;
  localparam logic [9:0]  RATIO_MAX = 10'h200;

  // frame period in core cycles per rate, window of one part in 32
  localparam int unsigned PER_W   = 12;
  localparam int unsigned P8K     = CLK_HZ / 8000;
  localparam int unsigned P16K    = CLK_HZ / 16000;
  localparam int unsigned P32K    = CLK_HZ / 32000;
  localparam int unsigned P48K    = CLK_HZ / 48000;
  localparam int unsigned P96K    = CLK_HZ / 96000;
  localparam int unsigned TOL_SH  = 5;

  // timeouts
  localparam int unsigned BCK_MISS_NS    = 10_000;
  localparam int unsigned BCK_MISS_CYC   = BCK_MISS_NS / CLK_PERIOD_NS;
  localparam int unsigned FRAME_TMO_NS   = 200_000;
  localparam int unsigned FRAME_TMO_CYC  = FRAME_TMO_NS / CLK_PERIOD_NS;

endpackage

/* hdl/acrm_sync.sv */
`timescale 1ns/1ns
module acrm_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

/* hdl/acrm_monitor.sv */
// Functional notes
// - rate field codes: 0 error, 2 8k, 4 16k, 6 32k, 9 48k, B 96k.
// - two top bits of bit clock ratio sit in rate monitor bits 5:4.
// - low eight ratio bits, bit clocks per frame, in their own register.
// - flag bit 5 marks bit clock above or below allowed rate.
// - flag bit 4 marks pll running above allowed rate.
// - flag bit 3 shows pll lock; disabled pll reads unlocked.
// - flag bit 2 marks missing bit clock.
// - flag bit 1 valid only for stable ratio within 32..512.
// - rate mode zero: flag bit 0 shows detected rate is valid.
// - rate mode nonzero: flag bit 0 set when configured and detected differ.
// - ignore option never suppresses the rate error flag.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
module acrm_monitor
  import acrm_pkg::*;
(
  // clock and reset
  input  wire logic                      core_clk_i,
  input  wire logic                      rst_n_i,
  // serial audio clocks from the source
  input  wire logic                      serial_bit_clock_i,
  input  wire logic                      frame_clk_i,
  // pll status
  input  wire logic                      pll_en_i,
  input  wire logic                      pll_locked_i,
  input  wire logic                      pll_overrate_i,
  // register port
  input  wire logic [acrm_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [acrm_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                      reg_wr_i,
  input  wire logic                      reg_rd_i,
  output logic      [acrm_pkg::DATA_W-1:0] reg_rdata_o,
  // interrupt
  output logic                           irq_o
);

  import acrm_pkg::*;

  localparam logic [PER_W-1:0] PER_SAT = '1;
  localparam logic [PER_W-1:0] TMO_CYC = PER_W'(FRAME_TMO_CYC);
  localparam logic [7:0]       MISS_CYC = 8'(BCK_MISS_CYC);
  localparam logic [RATIO_W-1:0] RATIO_SAT = '1;

  // pins cross in here
  logic [3:0] sync_w;
  logic       bck_s;
  logic       frm_s;
  logic       lock_s;
  logic       ovr_s;

  acrm_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({pll_overrate_i, pll_locked_i, frame_clk_i, serial_bit_clock_i}),
    .sync_o     (sync_w)
  );

  assign bck_s  = sync_w[0];
  assign frm_s  = sync_w[1];
  assign lock_s = sync_w[2];
  assign ovr_s  = sync_w[3];

  // measurement state
  logic               bck_d_ff,   nxt_bck_d;
  logic               frm_d_ff,   nxt_frm_d;
  logic               seen_ff,    nxt_seen;
  logic [RATIO_W-1:0] bck_cnt_ff, nxt_bck_cnt;
  logic [RATIO_W-1:0] ratio_ff,   nxt_ratio;
  logic [RATIO_W-1:0] prev_ff,    nxt_prev;
  logic               stable_ff,  nxt_stable;
  logic [PER_W-1:0]   per_cnt_ff, nxt_per_cnt;
  logic [3:0]         rate_ff,    nxt_rate;
  logic [7:0]         miss_ff,    nxt_miss;
  logic               bck_rise;
  logic               frm_rise;

  function automatic logic near(input logic [PER_W-1:0] p, input int unsigned nom);
    int unsigned lo;
    int unsigned hi;
    lo = nom - (nom >> TOL_SH);
    hi = nom + (nom >> TOL_SH);
    near = (32'(p) >= lo) && (32'(p) <= hi);
  endfunction

  function automatic logic [3:0] classify(input logic [PER_W-1:0] p);
    classify = RATE_ERR;
    if (near(p, P8K)) begin
      classify = RATE_8K;
    end else if (near(p, P16K)) begin
      classify = RATE_16K;
    end else if (near(p, P32K)) begin
      classify = RATE_32K;
    end else if (near(p, P48K)) begin
      classify = RATE_48K;
    end else if (near(p, P96K)) begin
      classify = RATE_96K;
    end
  endfunction

  always_comb begin
    bck_rise    = bck_s & ~bck_d_ff;
    frm_rise    = frm_s & ~frm_d_ff;
    nxt_bck_d   = bck_s;
    nxt_frm_d   = frm_s;
    nxt_seen    = seen_ff;
    nxt_ratio   = ratio_ff;
    nxt_prev    = prev_ff;
    nxt_stable  = stable_ff;
    nxt_rate    = rate_ff;
    nxt_bck_cnt = bck_cnt_ff;
    nxt_per_cnt = (per_cnt_ff == PER_SAT) ? per_cnt_ff : per_cnt_ff + 1'b1;
    nxt_miss    = (miss_ff == MISS_CYC) ? miss_ff : miss_ff + 8'h01;
    if (bck_rise) begin
      nxt_miss = 8'h00;
      if (bck_cnt_ff != RATIO_SAT) begin
        nxt_bck_cnt = bck_cnt_ff + 1'b1;
      end
    end
    if (frm_rise) begin
      // first edge only opens a frame; no period to judge yet
      nxt_seen    = 1'b1;
      nxt_per_cnt = '0;
      nxt_bck_cnt = bck_rise ? RATIO_W'(1) : '0;
      if (seen_ff) begin
        nxt_ratio  = bck_cnt_ff;
        nxt_prev   = ratio_ff;
        nxt_stable = (bck_cnt_ff == ratio_ff);
        nxt_rate   = classify(per_cnt_ff);
      end
    end else if (per_cnt_ff >= TMO_CYC) begin
      // frame clock stopped: nothing measured is current any more
      nxt_seen   = 1'b0;
      nxt_rate   = RATE_ERR;
      nxt_stable = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bck_d_ff   <= 1'b0;
      frm_d_ff   <= 1'b0;
      seen_ff    <= 1'b0;
      bck_cnt_ff <= '0;
      ratio_ff   <= '0;
      prev_ff    <= '0;
      stable_ff  <= 1'b0;
      per_cnt_ff <= '0;
      rate_ff    <= RATE_ERR;
      miss_ff    <= '0;
    end else begin
      bck_d_ff   <= nxt_bck_d;
      frm_d_ff   <= nxt_frm_d;
      seen_ff    <= nxt_seen;
      bck_cnt_ff <= nxt_bck_cnt;
      ratio_ff   <= nxt_ratio;
      prev_ff    <= nxt_prev;
      stable_ff  <= nxt_stable;
      per_cnt_ff <= nxt_per_cnt;
      rate_ff    <= nxt_rate;
      miss_ff    <= nxt_miss;
    end
  end

  // detection flags
  logic [5:0] flags_ff, nxt_flags;
  logic [4:0] ctrl_ff,  nxt_ctrl;
  logic       in_range;

  always_comb begin
    in_range  = (ratio_ff >= RATIO_MIN) && (ratio_ff <= RATIO_MAX);
    nxt_flags = '0;
    nxt_flags[FLG_BCK_MISS]  = (miss_ff == MISS_CYC);
    nxt_flags[FLG_BCK_RATE]  = seen_ff && !in_range && (miss_ff != MISS_CYC);
    nxt_flags[FLG_PLL_OVR]   = ovr_s;
    nxt_flags[FLG_PLL_LOCK]  = pll_en_i & lock_s;
    nxt_flags[FLG_BCK_VALID] = stable_ff && in_range && (miss_ff != MISS_CYC);
    if (ctrl_ff[3:0] == 4'h0) begin
      nxt_flags[FLG_RATE] = (rate_ff != RATE_ERR);
    end else begin
      // ignore bit deliberately not consulted here
      nxt_flags[FLG_RATE] = (ctrl_ff[3:0] != rate_ff);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_ff <= RST_CLK_DETECT_FLAGS[5:0];
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  // register file and interrupts
  logic [1:0]        rsv_rate_ff, nxt_rsv_rate;
  logic [1:0]        rsv_flag_ff, nxt_rsv_flag;
  logic [IRQ_N-1:0]  irq_st_ff,   nxt_irq_st;
  logic [IRQ_N-1:0]  irq_msk_ff,  nxt_irq_msk;
  logic [IRQ_N-1:0]  ev;
  logic [IRQ_N-1:0]  clr;
  logic [7:0]        rdata_ff,    nxt_rdata;
  logic              irq_ff,      nxt_irq;
  logic              rate_err;

  always_comb begin
    rate_err = (ctrl_ff[3:0] == 4'h0) ? !flags_ff[FLG_RATE] : flags_ff[FLG_RATE];
    // events other than rate error are rising edges of the fault conditions
    ev = '0;
    ev[IRQ_BCK_MISS] = nxt_flags[FLG_BCK_MISS] & ~flags_ff[FLG_BCK_MISS];
    ev[IRQ_BCK_RATE] = nxt_flags[FLG_BCK_RATE] & ~flags_ff[FLG_BCK_RATE];
    ev[IRQ_PLL_UNLK] = ~nxt_flags[FLG_PLL_LOCK] & flags_ff[FLG_PLL_LOCK];
    ev[IRQ_PLL_OVR]  = nxt_flags[FLG_PLL_OVR] & ~flags_ff[FLG_PLL_OVR];
    // the rate error event stays zero with or without ignore, as rate_err cancels the edge; the flag itself still rises
    ev[IRQ_RATE_ERR] = ~ctrl_ff[CTRL_IGNORE] & rate_err &
                       ((ctrl_ff[3:0] == 4'h0) ? ~nxt_flags[FLG_RATE] & flags_ff[FLG_RATE]
                                               : nxt_flags[FLG_RATE] & ~flags_ff[FLG_RATE]);
    clr = '0;
    nxt_rsv_rate = rsv_rate_ff;
    nxt_rsv_flag = rsv_flag_ff;
    nxt_ctrl     = ctrl_ff;
    nxt_irq_msk  = irq_msk_ff;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        OFS_SAMPLE_RATE_MON:  nxt_rsv_rate = reg_wdata_i[RSV_LSB +: 2];
        OFS_CLK_DETECT_FLAGS: nxt_rsv_flag = reg_wdata_i[RSV_LSB +: 2];
        OFS_RATE_CTRL:        nxt_ctrl     = reg_wdata_i[4:0];
        OFS_IRQ_STATUS:       clr          = reg_wdata_i[IRQ_N-1:0];
        OFS_IRQ_MASK:         nxt_irq_msk  = reg_wdata_i[IRQ_N-1:0];
        default: begin
        end
      endcase
    end
    // a new event beats a clear in the same cycle
    nxt_irq_st = (irq_st_ff & ~clr) | ev;
    nxt_irq    = |(nxt_irq_st & nxt_irq_msk);
    nxt_rdata  = 8'h00;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        OFS_SAMPLE_RATE_MON:  nxt_rdata = {rsv_rate_ff, ratio_ff[9:8], rate_ff};
        OFS_BIT_CLK_RATIO_LO: nxt_rdata = ratio_ff[7:0];
        OFS_CLK_DETECT_FLAGS: nxt_rdata = {rsv_flag_ff, flags_ff};
        OFS_RATE_CTRL:        nxt_rdata = {3'h0, ctrl_ff};
        OFS_IRQ_STATUS:       nxt_rdata = {3'h0, irq_st_ff};
        OFS_IRQ_MASK:         nxt_rdata = {3'h0, irq_msk_ff};
        default:              nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rsv_rate_ff <= RST_SAMPLE_RATE_MON[RSV_LSB +: 2];
      rsv_flag_ff <= RST_CLK_DETECT_FLAGS[RSV_LSB +: 2];
      ctrl_ff     <= RST_RATE_CTRL;
      irq_st_ff   <= RST_IRQ;
      irq_msk_ff  <= RST_IRQ;
      rdata_ff    <= 8'h00;
      irq_ff      <= 1'b0;
    end else begin
      rsv_rate_ff <= nxt_rsv_rate;
      rsv_flag_ff <= nxt_rsv_flag;
      ctrl_ff     <= nxt_ctrl;
      irq_st_ff   <= nxt_irq_st;
      irq_msk_ff  <= nxt_irq_msk;
      rdata_ff    <= nxt_rdata;
      irq_ff      <= nxt_irq;
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign irq_o       = irq_ff;

endmodule

/* test/acrm_audio_src.sv */
`timescale 1ns/1ns
module acrm_audio_src #(
  parameter int unsigned HALF_NS = 400
) (
  // control from the bench
  input  wire logic       run_i,
  input  wire logic [9:0] bits_i,
  // serial clocks to the monitor
  output logic            serial_bit_clock_o,
  output logic            frame_clk_o
);
  logic [9:0] cnt;

  initial begin
    serial_bit_clock_o = 1'b0;
    frame_clk_o        = 1'b0;
    cnt                = 10'h000;
    #137;
    forever begin
      #(HALF_NS);
      // stands low when stopped, never free running
      serial_bit_clock_o = run_i ? ~serial_bit_clock_o : 1'b0;
    end
  end

  // frame moves on a falling edge so each frame holds whole bit clocks
  always @(negedge serial_bit_clock_o) begin
    cnt         = (cnt + 10'h001 >= bits_i) ? 10'h000 : cnt + 10'h001;
    frame_clk_o = (cnt < (bits_i >> 1));
  end
endmodule

/* test/acrm_check_monitor.sv */
`timescale 1ns/1ns
module acrm_check
  import acrm_pkg::*;
(
  // clock and reset
  input wire logic              core_clk_i,
  input wire logic              rst_n_i,
  // link and pll
  input wire logic              serial_bit_clock_i,
  input wire logic              frame_clk_i,
  input wire logic              pll_en_i,
  input wire logic              pll_locked_i,
  input wire logic              pll_overrate_i,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr_i,
  input wire logic [DATA_W-1:0] reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [DATA_W-1:0] reg_rdata_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_rd_flags;
    reg_rd_i && reg_addr_i == OFS_CLK_DETECT_FLAGS;
  endsequence
  sequence s_rd_rate;
    reg_rd_i && reg_addr_i == OFS_SAMPLE_RATE_MON;
  endsequence

  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (reg_rd_i && !(reg_addr_i inside {[8'h37:8'h3C]}) |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rate_legal: assert property (s_rd_rate |=> reg_rdata_o[3:0] inside {4'h0, 4'h2, 4'h4, 4'h6, 4'h9, 4'hB})
    else $error("reserved rate code");
  a_pll_unlocked: assert property ((!pll_en_i)[*4] ##0 s_rd_flags |=> !reg_rdata_o[FLG_PLL_LOCK])
    else $error("disabled pll shown locked");
  a_pll_over: assert property (pll_overrate_i[*6] ##0 s_rd_flags |=> reg_rdata_o[FLG_PLL_OVR])
    else $error("pll overrate not shown");
  a_bck_present: assert property ($rose(serial_bit_clock_i) ##[10:40] s_rd_flags |=> !reg_rdata_o[FLG_BCK_MISS])
    else $error("running bit clock shown missing");
  a_valid_needs_clk: assert property (s_rd_flags |=> !(reg_rdata_o[FLG_BCK_VALID] && reg_rdata_o[FLG_BCK_MISS]))
    else $error("bit clock valid while missing");
  a_valid_in_range: assert property (s_rd_flags |=> !(reg_rdata_o[FLG_BCK_VALID] && reg_rdata_o[FLG_BCK_RATE]))
    else $error("bit clock valid while out of rate");
  a_irq_masked: assert property (reg_wr_i && reg_addr_i == OFS_IRQ_MASK && reg_wdata_i == 8'h00 |-> ##2 !irq_o)
    else $error("interrupt high with all masked");
endmodule

bind acrm_monitor acrm_check u_check (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .serial_bit_clock_i(serial_bit_clock_i),
  .frame_clk_i(frame_clk_i), .pll_en_i(pll_en_i), .pll_locked_i(pll_locked_i),
  .pll_overrate_i(pll_overrate_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o)
);

/* test/acrm_monitor_tb.sv */
`timescale 1ns/1ns
module acrm_monitor_tb;
  import acrm_pkg::*;
  logic       clk, rst_n, serial_bit_clock, frm, pen, plk, pov, wr, rd, irq, run;
  logic [7:0] addr, wd, rdat;
  logic [9:0] bits;
  int         n_errors, checks;
  logic [9:0] t_bits [6] = '{10'h09C, 10'h04E, 10'h027, 10'h01A, 10'h032, 10'h00D};
  logic [3:0] t_code [6] = '{RATE_8K, RATE_16K, RATE_32K, RATE_48K, RATE_ERR, RATE_96K};
  logic [7:0] t_flg  [6] = '{8'h0B, 8'h0B, 8'h0B, 8'h29, 8'h0A, 8'h29};
  logic [7:0] m_ctl  [3] = '{8'h0B, 8'h02, 8'h12};
  logic [7:0] m_exp  [3] = '{8'h00, 8'h01, 8'h01};

  acrm_audio_src SRC (.run_i(run), .bits_i(bits), .serial_bit_clock_o(serial_bit_clock), .frame_clk_o(frm));
  acrm_monitor DUT (
    .core_clk_i(clk), .rst_n_i(rst_n), .serial_bit_clock_i(serial_bit_clock), .frame_clk_i(frm),
    .pll_en_i(pen), .pll_locked_i(plk), .pll_overrate_i(pov), .reg_addr_i(addr),
    .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .irq_o(irq)
  );

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd   <= d;
    wr   <= 1'b1;
    @(posedge clk);
    wr   <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    chk(n, e, rdat & m);
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(60_000 * CLK_PERIOD_NS);
    n_errors++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    {clk, rst_n, pen, plk, pov, wr, rd, run} = 8'h00;
    addr = 8'h00;
    wd   = 8'h00;
    bits = 10'h040;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk("reset", 8'h37 + i[7:0], 8'hFF, 8'h00);
    wr_reg(OFS_SAMPLE_RATE_MON, 8'hFF);
    rd_chk("rsv", OFS_SAMPLE_RATE_MON, 8'hFF, 8'hC0);
    wr_reg(OFS_BIT_CLK_RATIO_LO, 8'hFF);
    rd_chk("ro", OFS_BIT_CLK_RATIO_LO, 8'hFF, 8'h00);
    wr_reg(8'h40, 8'hFF);
    rd_chk("unmapped", 8'h40, 8'hFF, 8'h00);
    wr_reg(OFS_SAMPLE_RATE_MON, 8'h00);
    pen <= 1'b1;
    plk <= 1'b1;
    run <= 1'b1;
    // four frames: partial, first full, then two equal ratios
    for (int i = 0; i < 6; i++) begin
      bits <= t_bits[i];
      repeat (32 * t_bits[i] + 40) @(posedge clk);
      rd_chk("rate", OFS_SAMPLE_RATE_MON, 8'h3F, {4'h0, t_code[i]});
      rd_chk("ratio", OFS_BIT_CLK_RATIO_LO, 8'hFF, t_bits[i][7:0]);
      rd_chk("flags", OFS_CLK_DETECT_FLAGS, 8'h3F, t_flg[i]);
    end
    for (int i = 0; i < 3; i++) begin
      wr_reg(OFS_RATE_CTRL, m_ctl[i]);
      repeat (150) @(posedge clk);
      rd_chk("mode", OFS_CLK_DETECT_FLAGS, 8'h01, m_exp[i]);
    end
    wr_reg(OFS_RATE_CTRL, 8'h00);
    pen <= 1'b0;
    repeat (10) @(posedge clk);
    rd_chk("lock_off", OFS_CLK_DETECT_FLAGS, 8'h08, 8'h00);
    pen <= 1'b1;
    pov <= 1'b1;
    repeat (10) @(posedge clk);
    rd_chk("pll_on", OFS_CLK_DETECT_FLAGS, 8'h18, 8'h18);
    pov <= 1'b0;
    plk <= 1'b0;
    repeat (10) @(posedge clk);
    rd_chk("pll_off", OFS_CLK_DETECT_FLAGS, 8'h18, 8'h00);
    wr_reg(OFS_IRQ_STATUS, 8'h1F);
    wr_reg(OFS_IRQ_MASK, 8'h01);
    run <= 1'b0;
    repeat (150) @(posedge clk);
    @(negedge clk);
    chk("irq_set", 8'h01, {7'h00, irq});
    rd_chk("missing", OFS_CLK_DETECT_FLAGS, 8'h06, 8'h04);
    rd_chk("status", OFS_IRQ_STATUS, 8'h01, 8'h01);
    wr_reg(OFS_IRQ_MASK, 8'h00);
    repeat (3) @(negedge clk);
    chk("irq_mask", 8'h00, {7'h00, irq});
    wr_reg(OFS_IRQ_MASK, 8'h01);
    repeat (3) @(negedge clk);
    chk("irq_unmask", 8'h01, {7'h00, irq});
    wr_reg(OFS_IRQ_STATUS, 8'h01);
    repeat (3) @(negedge clk);
    chk("irq_clear", 8'h00, {7'h00, irq});
    rd_chk("cleared", OFS_IRQ_STATUS, 8'h01, 8'h00);
    wrap_up();
  end
endmodule
